/* File: core/swp_core.sv */
// Sector write protection core: persistent and volatile protection bits,
// the lock over the persistent bits, and their command sequencer.
// Assumes an APB master on clk_sys and a hardware reset pin from outside.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "swp_params.svh"

module swp_core #(
  parameter int unsigned PROG_CYCLES = `SWP_PROG_TIME_US * `SWP_CLK_MHZ,
  parameter int unsigned PREPROG_CYCLES = `SWP_PREPROG_TIME_US * `SWP_CLK_MHZ,
  parameter int unsigned ERASE_CYCLES = `SWP_ERASE_TIME_US * `SWP_CLK_MHZ,
  parameter int unsigned UNLOCK_FAIL_CYCLES = `SWP_UNLOCK_FAIL_US * `SWP_CLK_MHZ
) (
  // Clock and power-up reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Hardware reset pin, active low
  input wire logic hwReset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Array protection query
  input wire logic [`SWP_ADDR_W-1:0] chkAddr,
  output logic chkProtected,
  output logic arrayReadBlock,
  output swp_pkg::swp_status_t status
);

  // ========================================================================
  // Address to protection unit
  function automatic logic [`SWP_IDX_W-1:0] unitIdx(input logic [`SWP_ADDR_W-1:0] a);
    if (a[24:16] >= `SWP_SMALL_BLOCK) begin
      unitIdx = `SWP_IDX_W'(`SWP_SMALL_IDX + `SWP_IDX_W'(a[24:12] - `SWP_SMALL_SECTOR));
    end else begin
      unitIdx = {1'b0, a[24:16]};
    end
  endfunction : unitIdx

  function automatic logic unitStart(input logic [31:0] a);
    if (a[31:`SWP_ADDR_W] != 7'h00) begin
      unitStart = 1'b0;
    end else if (a[24:16] >= `SWP_SMALL_BLOCK) begin
      unitStart = (a[11:0] == 12'h000);
    end else begin
      unitStart = (a[15:0] == 16'h0000);
    end
  endfunction : unitStart

  // ========================================================================
  // Declarations
  logic hwRstMeta_q;
  logic hwRstSync_q;
  logic [31:0] addr_q;
  logic mode_q;
  logic [63:0] pwd_q;
  logic [63:0] key_q;
  logic [`SWP_UNITS-1:0] persBits_q;
  logic [`SWP_UNITS-1:0] volBits_q;
  logic lock_q;
  logic progErr_q;
  logic eraseErr_q;
  logic protErr_q;
  logic persRd_q;
  logic volRd_q;
  logic [`SWP_CNT_W-1:0] cnt_q;
  logic [`SWP_IDX_W-1:0] opIdx_q;
  swp_pkg::swp_state_t state_q;
  swp_pkg::swp_state_t state_d;
  swp_pkg::swp_cmd_t cmd;
  logic wrEn;
  logic rdSetup;
  logic cmdGo;
  logic busy;
  logic cntDone;
  logic hwRst;
  logic [`SWP_IDX_W-1:0] cmdIdx;
  logic addrOk;
  logic pwdMatch;
  logic setProgErr;
  logic setEraseErr;
  logic setProtErr;
  logic mapped;

  // ========================================================================
  // Hardware reset pin synchroniser
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hwRstMeta_q <= 1'b0;
      hwRstSync_q <= 1'b0;
    end else begin
      hwRstMeta_q <= ~hwReset_n;
      hwRstSync_q <= hwRstMeta_q;
    end
  end
  assign hwRst = hwRstSync_q;

  // ========================================================================
  // APB decode
  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdSetup = psel & ~penable;
  assign cmd = swp_pkg::swp_cmd_t'(pwdata[`SWP_CMD_VAL_BIT:0]);
  assign busy = (state_q != swp_pkg::SWP_ST_IDLE);
  // Commands arriving while busy are dropped; software polls busy first
  assign cmdGo = wrEn & (paddr == `SWP_OFF_CMD) & ~busy & ~hwRst;
  assign cmdIdx = unitIdx(addr_q[`SWP_ADDR_W-1:0]);
  assign addrOk = unitStart(addr_q);
  assign pwdMatch = (key_q == pwd_q);

  always_comb begin
    case (paddr)
      `SWP_OFF_CMD, `SWP_OFF_ADDR, `SWP_OFF_STATUS, `SWP_OFF_CONFIG,
      `SWP_OFF_PWD_LO, `SWP_OFF_PWD_HI, `SWP_OFF_KEY_LO, `SWP_OFF_KEY_HI: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign status = '{modePersistent: mode_q, volRd: volRd_q, persRd: persRd_q, protErr: protErr_q,
                    eraseErr: eraseErr_q, progErr: progErr_q, lock: lock_q, busy: busy};

  // Read data and error are registered in the setup cycle, so pready can stay high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rdSetup) begin
      pslverr <= ~mapped;
      case (paddr)
        `SWP_OFF_ADDR: prdata <= addr_q;
        `SWP_OFF_STATUS: prdata <= {24'h000000, status};
        `SWP_OFF_CONFIG: prdata <= {31'h00000000, mode_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ========================================================================
  // Software registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 32'h00000000;
      key_q <= 64'h0000000000000000;
    end else if (wrEn) begin
      if (paddr == `SWP_OFF_ADDR) begin
        addr_q <= pwdata;
      end
      if (paddr == `SWP_OFF_KEY_LO) begin
        key_q[31:0] <= pwdata;
      end
      if (paddr == `SWP_OFF_KEY_HI) begin
        key_q[63:32] <= pwdata;
      end
    end
  end

  // One-time bits: writes can only clear, so a mode once chosen stays
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `SWP_MODE_RESET;
      pwd_q <= `SWP_PWD_RESET;
    end else if (wrEn) begin
      if (paddr == `SWP_OFF_CONFIG) begin
        mode_q <= mode_q & pwdata[`SWP_CFG_MODE_BIT];
      end
      if (paddr == `SWP_OFF_PWD_LO) begin
        pwd_q[31:0] <= pwd_q[31:0] & pwdata;
      end
      if (paddr == `SWP_OFF_PWD_HI) begin
        pwd_q[63:32] <= pwd_q[63:32] & pwdata;
      end
    end
  end

  // ========================================================================
  // Sequencer
  assign cntDone = (cnt_q == `SWP_CNT_W'(0));

  always_comb begin
    state_d = state_q;
    case (state_q)
      swp_pkg::SWP_ST_IDLE: begin
        if (cmdGo && lock_q && cmd.op == swp_pkg::SWP_OP_PERS_PROG && addrOk) begin
          state_d = swp_pkg::SWP_ST_PROG;
        end else if (cmdGo && lock_q && cmd.op == swp_pkg::SWP_OP_PERS_ERASE) begin
          state_d = swp_pkg::SWP_ST_PREPROG;
        end else if (cmdGo && cmd.op == swp_pkg::SWP_OP_PWD_UNLOCK && !mode_q && !pwdMatch) begin
          state_d = swp_pkg::SWP_ST_UNLOCK;
        end
      end
      swp_pkg::SWP_ST_PROG: if (cntDone) state_d = swp_pkg::SWP_ST_IDLE;
      swp_pkg::SWP_ST_PREPROG: if (cntDone) state_d = swp_pkg::SWP_ST_ERASE;
      swp_pkg::SWP_ST_ERASE: if (cntDone) state_d = swp_pkg::SWP_ST_IDLE;
      swp_pkg::SWP_ST_UNLOCK: if (cntDone) state_d = swp_pkg::SWP_ST_IDLE;
      default: state_d = swp_pkg::SWP_ST_IDLE;
    endcase
    if (hwRst) begin
      state_d = swp_pkg::SWP_ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= swp_pkg::SWP_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Counter loads on each state entry and counts down to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `SWP_CNT_W'(0);
      opIdx_q <= `SWP_IDX_W'(0);
    end else if (state_d != state_q) begin
      case (state_d)
        swp_pkg::SWP_ST_PROG: cnt_q <= `SWP_CNT_W'(PROG_CYCLES - 1);
        swp_pkg::SWP_ST_PREPROG: cnt_q <= `SWP_CNT_W'(PREPROG_CYCLES - 1);
        swp_pkg::SWP_ST_ERASE: cnt_q <= `SWP_CNT_W'(ERASE_CYCLES - 1);
        swp_pkg::SWP_ST_UNLOCK: cnt_q <= `SWP_CNT_W'(UNLOCK_FAIL_CYCLES - 1);
        default: cnt_q <= `SWP_CNT_W'(0);
      endcase
      if (state_q == swp_pkg::SWP_ST_IDLE) begin
        opIdx_q <= cmdIdx;
      end
    end else if (!cntDone) begin
      cnt_q <= cnt_q - `SWP_CNT_W'(1);
    end
  end

  // ========================================================================
  // Persistent bits: power-up value erased, never touched by hardware reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      persBits_q <= '1;
    end else if (cntDone && !hwRst) begin
      case (state_q)
        swp_pkg::SWP_ST_PROG: persBits_q[opIdx_q] <= 1'b0;
        swp_pkg::SWP_ST_PREPROG: persBits_q <= '0;
        swp_pkg::SWP_ST_ERASE: persBits_q <= '1;
        default: persBits_q <= persBits_q;
      endcase
    end
  end

  // ========================================================================
  // Volatile bits: unprotected after any reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      volBits_q <= '1;
    end else if (hwRst) begin
      volBits_q <= '1;
    end else if (cmdGo && cmd.op == swp_pkg::SWP_OP_VOL_WRITE && addrOk) begin
      volBits_q[cmdIdx] <= cmd.value;
    end
  end

  // ========================================================================
  // Lock over the persistent bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= `SWP_MODE_RESET;
    end else if (hwRst) begin
      lock_q <= mode_q;
    end else if (cmdGo && cmd.op == swp_pkg::SWP_OP_LOCK_CLEAR) begin
      lock_q <= 1'b0;
    end else if (cmdGo && cmd.op == swp_pkg::SWP_OP_PWD_UNLOCK && !mode_q && pwdMatch) begin
      lock_q <= 1'b1;
    end
  end

  // ========================================================================
  // Error flags: set wins over a same-cycle write-one clear
  assign setProgErr = cmdGo && ((cmd.op == swp_pkg::SWP_OP_PERS_PROG && (!lock_q || !addrOk)) ||
                                (cmd.op == swp_pkg::SWP_OP_PWD_UNLOCK && (mode_q || !pwdMatch)));
  assign setEraseErr = cmdGo && cmd.op == swp_pkg::SWP_OP_PERS_ERASE && !lock_q;
  assign setProtErr = setProgErr || setEraseErr ||
                      (cmdGo && (cmd.op == swp_pkg::SWP_OP_PERS_READ || cmd.op == swp_pkg::SWP_OP_VOL_READ ||
                                 cmd.op == swp_pkg::SWP_OP_VOL_WRITE) && !addrOk);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      progErr_q <= 1'b0;
      eraseErr_q <= 1'b0;
      protErr_q <= 1'b0;
    end else begin
      progErr_q <= setProgErr | (progErr_q & ~(wrEn && paddr == `SWP_OFF_STATUS && pwdata[2]));
      eraseErr_q <= setEraseErr | (eraseErr_q & ~(wrEn && paddr == `SWP_OFF_STATUS && pwdata[3]));
      protErr_q <= setProtErr | (protErr_q & ~(wrEn && paddr == `SWP_OFF_STATUS && pwdata[4]));
    end
  end

  // ========================================================================
  // Bit read results, ready one cycle after the command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      persRd_q <= 1'b1;
      volRd_q <= 1'b1;
    end else if (cmdGo && addrOk) begin
      if (cmd.op == swp_pkg::SWP_OP_PERS_READ) begin
        persRd_q <= persBits_q[cmdIdx];
      end
      if (cmd.op == swp_pkg::SWP_OP_VOL_READ) begin
        volRd_q <= volBits_q[cmdIdx];
      end
    end
  end

  // ========================================================================
  // Array side: protection query and read blocking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chkProtected <= 1'b0;
      arrayReadBlock <= 1'b0;
    end else begin
      chkProtected <= ~(persBits_q[unitIdx(chkAddr)] & volBits_q[unitIdx(chkAddr)]);
      arrayReadBlock <= (state_d == swp_pkg::SWP_ST_PROG);
    end
  end

endmodule : swp_core
`default_nettype wire

/* File: inc/swp_params.svh */
// Constants of the sector write protection block: register offsets, field
// positions, reset values, mapping figures and operation times.
// Assumes a 50 MHz system clock and 32-bit APB data.
`ifndef SWP_PARAMS_SVH
`define SWP_PARAMS_SVH

// ==========================================================================
// Array geometry and unit mapping
`define SWP_UNITS 542
`define SWP_IDX_W 10
`define SWP_ADDR_W 25
`define SWP_SMALL_BLOCK 9'h1fe
`define SWP_SMALL_SECTOR 13'h1fe0
`define SWP_SMALL_IDX 10'h1fe

// ==========================================================================
// Register offsets (byte addresses)
`define SWP_OFF_CMD 12'h000
`define SWP_OFF_ADDR 12'h004
`define SWP_OFF_STATUS 12'h008
`define SWP_OFF_CONFIG 12'h00c
`define SWP_OFF_PWD_LO 12'h010
`define SWP_OFF_PWD_HI 12'h014
`define SWP_OFF_KEY_LO 12'h018
`define SWP_OFF_KEY_HI 12'h01c

// ==========================================================================
// Field positions
`define SWP_CMD_OP_MSB 3
`define SWP_CMD_VAL_BIT 4
`define SWP_CFG_MODE_BIT 0

// ==========================================================================
// Reset values
`define SWP_PWD_RESET 64'hffffffffffffffff
`define SWP_MODE_RESET 1'b1

// ==========================================================================
// Times
`define SWP_CLK_MHZ 50
`define SWP_PROG_TIME_US 200
`define SWP_PREPROG_TIME_US 200
`define SWP_ERASE_TIME_US 1000
`define SWP_UNLOCK_FAIL_US 100
`define SWP_CNT_W 24

`endif

/* File: inc/swp_pkg.sv */
// Types of the sector write protection block.
// Takes nothing from swp_params.svh; the command and state codes are set here.
`default_nettype none
package swp_pkg;

  // ========================================================================
  // Command codes
  typedef enum logic [3:0] {
    SWP_OP_NOP = 4'h0,
    SWP_OP_PERS_PROG = 4'h1,
    SWP_OP_PERS_ERASE = 4'h2,
    SWP_OP_PERS_READ = 4'h3,
    SWP_OP_VOL_WRITE = 4'h4,
    SWP_OP_VOL_READ = 4'h5,
    SWP_OP_LOCK_CLEAR = 4'h6,
    SWP_OP_PWD_UNLOCK = 4'h7
  } swp_op_t;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    SWP_ST_IDLE = 3'b000,
    SWP_ST_PROG = 3'b001,
    SWP_ST_PREPROG = 3'b010,
    SWP_ST_ERASE = 3'b011,
    SWP_ST_UNLOCK = 3'b100
  } swp_state_t;

  // ========================================================================
  // Command word and status word
  typedef struct packed {
    logic value;
    swp_op_t op;
  } swp_cmd_t;

  typedef struct packed {
    logic modePersistent;
    logic volRd;
    logic persRd;
    logic protErr;
    logic eraseErr;
    logic progErr;
    logic lock;
    logic busy;
  } swp_status_t;

endpackage : swp_pkg
`default_nettype wire

/* File: bench/swp_core_props.sv */
// Checker for swp_core: timing and lock relations seen at the core's ports.
// Assumes one clock domain and the register map of swp_params.svh.
`timescale 1ns/1ns
`default_nettype none
`include "swp_params.svh"
module swp_core_props #(
  parameter int unsigned PROG_CYCLES = 4
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hwReset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Query and status
  input wire logic [`SWP_ADDR_W-1:0] chkAddr,
  input wire logic chkProtected,
  input wire logic arrayReadBlock,
  input wire swp_pkg::swp_status_t status
);
  // ========================================================================
  // Helpers
  logic [2:0] hwHist_q;
  int unsigned progCnt_q;
  logic hwQuiet;
  logic cmdOk;
  // Commands are dropped while the synchronised hardware reset may still act
  assign hwQuiet = hwReset_n && (&hwHist_q);
  assign cmdOk = psel && penable && pwrite && paddr == `SWP_OFF_CMD && !status.busy && hwQuiet;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hwHist_q <= 3'h0;
    else hwHist_q <= {hwHist_q[1:0], hwReset_n};
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) progCnt_q <= 0;
    else progCnt_q <= arrayReadBlock ? progCnt_q + 1 : 0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ========================================================================
  // Properties
  a_prog_length: assert property (disable iff (!rst_n || !hwReset_n)
    $fell(arrayReadBlock) |-> progCnt_q == PROG_CYCLES) else $error("program length wrong");
  a_block_busy: assert property (arrayReadBlock |-> status.busy) else $error("read block while idle");
  a_locked_prog: assert property (cmdOk && pwdata[3:0] == swp_pkg::SWP_OP_PERS_PROG && !status.lock
    |=> !status.busy && status.progErr && status.protErr) else $error("locked program not refused");
  a_locked_erase: assert property (cmdOk && pwdata[3:0] == swp_pkg::SWP_OP_PERS_ERASE && !status.lock
    |=> !status.busy && status.eraseErr && status.protErr) else $error("locked erase not refused");
  a_lock_clear: assert property (cmdOk && pwdata[3:0] == swp_pkg::SWP_OP_LOCK_CLEAR
    |=> !status.lock) else $error("lock not cleared");
  a_lock_stays: assert property (hwQuiet && status.modePersistent && !status.lock
    |=> !status.lock) else $error("lock set without reset");
  a_hw_lock: assert property (!hwReset_n [*5] |-> status.lock == status.modePersistent)
    else $error("lock wrong under hardware reset");
  a_unlock_refused: assert property (cmdOk && pwdata[3:0] == swp_pkg::SWP_OP_PWD_UNLOCK
    && status.modePersistent |=> status.progErr && status.protErr && status.lock == $past(status.lock))
    else $error("unlock not refused");
endmodule : swp_core_props
bind swp_core swp_core_props #(.PROG_CYCLES(PROG_CYCLES)) u_swp_core_props (.clk_sys, .rst_n, .hwReset_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .chkAddr, .chkProtected,
  .arrayReadBlock, .status);
`default_nettype wire

/* File: bench/swp_host.sv */
// Host controller model: an APB master issuing protection commands.
// Assumes the bench calls xfer and never runs two transfers at once.
`timescale 1ns/1ns
`default_nettype none
module swp_host (
  // Clock
  input wire logic clk_sys,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // ========================================================================
  // One transfer; addresses handed in are unit starts unless a refusal is meant
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : swp_host
`default_nettype wire

/* File: bench/swp_core_tb_top.sv */
// Testbench for swp_core: command sequences over APB with expected results.
// Assumes short operation counts set below and the checker bound in.
`timescale 1ns/1ns
`default_nettype none
`include "swp_params.svh"
module swp_core_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hwReset_n = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, chkProtected, arrayReadBlock, errQ, sawBlock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdQ, busyCnt;
  logic [`SWP_ADDR_W-1:0] chkAddr = '0;
  swp_pkg::swp_status_t status;
  int failCount = 0;
  int nTests = 0;
  always #10 clk_sys = ~clk_sys;
  swp_core #(.PROG_CYCLES(4), .PREPROG_CYCLES(4), .ERASE_CYCLES(8), .UNLOCK_FAIL_CYCLES(4)) u_swp_core (
    .clk_sys, .rst_n, .hwReset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chkAddr, .chkProtected, .arrayReadBlock, .status);
  swp_host u_swp_host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // ========================================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_swp_host.xfer(1'b1, a, d, rdQ, errQ);
  endtask : wr
  // Clears sticky flags first, so each command's flags stand alone
  task automatic cmd(input swp_pkg::swp_op_t op, input logic [31:0] a, input logic v);
    wr(`SWP_OFF_STATUS, 32'h1c);
    wr(`SWP_OFF_ADDR, a);
    wr(`SWP_OFF_CMD, {27'h0, v, op});
    sawBlock = 1'b0;
    busyCnt = 0;
    @(negedge clk_sys);
    while (status.busy !== 1'b0 && busyCnt < 100) begin
      sawBlock = sawBlock | arrayReadBlock;
      busyCnt++;
      @(negedge clk_sys);
    end
    // A command that never finishes counts against the run
    if (busyCnt >= 100) failCount++;
  endtask : cmd
  task automatic prot(input logic [24:0] a, input logic exp);
    @(posedge clk_sys);
    chkAddr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("chkProtected", chkProtected, exp);
  endtask : prot
  task automatic hw_pulse();
    @(posedge clk_sys);
    hwReset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    hwReset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : hw_pulse
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // Watchdog: the sequence needs a few hundred cycles
  initial begin
    #200000;
    failCount++;
    complete_run();
  end
  // ========================================================================
  // Sequence
  initial begin
    logic [31:0] rdA [6] = '{32'h40000, 32'h50000, 32'h60000, 32'h1fe0000, 32'h1fe1000, 32'h1ff0000};
    logic rdE [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("status", status, 32'he2);
    u_swp_host.xfer(1'b0, `SWP_OFF_STATUS, 32'h0, rdQ, errQ);
    chk("statusRd", rdQ, 32'he2);
    chk("statusErr", errQ, 1'b0);
    u_swp_host.xfer(1'b0, 12'h020, 32'h0, rdQ, errQ);
    chk("unmapped", {rdQ[30:0], errQ}, 32'h1);
    cmd(swp_pkg::SWP_OP_PERS_READ, 32'h0, 1'b0);
    chk("persRd", status.persRd, 1);
    cmd(swp_pkg::SWP_OP_PERS_PROG, 32'h50000, 1'b0);
    chk("arrayReadBlock", sawBlock, 1);
    chk("progCycles", busyCnt, 4);
    cmd(swp_pkg::SWP_OP_PERS_PROG, 32'h1fe1000, 1'b0);
    foreach (rdA[i]) begin
      cmd(swp_pkg::SWP_OP_PERS_READ, rdA[i], 1'b0);
      chk("persRd", status.persRd, rdE[i]);
    end
    cmd(swp_pkg::SWP_OP_PERS_READ, 32'h50004, 1'b0);
    chk("protErr", status.protErr, 1);
    u_swp_host.xfer(1'b0, `SWP_OFF_ADDR, 32'h0, rdQ, errQ);
    chk("addrRd", rdQ, 32'h50004);
    prot(25'h50010, 1'b1);
    prot(25'h60000, 1'b0);
    cmd(swp_pkg::SWP_OP_VOL_WRITE, 32'h60000, 1'b0);
    prot(25'h60000, 1'b1);
    cmd(swp_pkg::SWP_OP_VOL_READ, 32'h60000, 1'b0);
    chk("volRd", status.volRd, 0);
    cmd(swp_pkg::SWP_OP_VOL_WRITE, 32'h60000, 1'b1);
    prot(25'h60000, 1'b0);
    cmd(swp_pkg::SWP_OP_VOL_WRITE, 32'h50000, 1'b1);
    prot(25'h50000, 1'b1);
    cmd(swp_pkg::SWP_OP_PERS_ERASE, 32'hab0000, 1'b0);
    chk("eraseCycles", busyCnt, 12);
    cmd(swp_pkg::SWP_OP_PERS_READ, 32'h50000, 1'b0);
    chk("persRd", status.persRd, 1);
    cmd(swp_pkg::SWP_OP_PERS_PROG, 32'h90000, 1'b0);
    // Bits are configured before the lock is dropped
    cmd(swp_pkg::SWP_OP_LOCK_CLEAR, 32'h0, 1'b0);
    chk("lock", status.lock, 0);
    cmd(swp_pkg::SWP_OP_PERS_PROG, 32'h70000, 1'b0);
    chk("progRefused", {status.progErr, status.protErr, status.busy}, 3'b110);
    cmd(swp_pkg::SWP_OP_PERS_ERASE, 32'h0, 1'b0);
    chk("eraseRefused", {status.eraseErr, status.protErr, status.busy}, 3'b110);
    cmd(swp_pkg::SWP_OP_PERS_READ, 32'h90000, 1'b0);
    chk("persRd", status.persRd, 0);
    cmd(swp_pkg::SWP_OP_PWD_UNLOCK, 32'h0, 1'b0);
    chk("unlockRefused", {status.progErr, status.protErr, status.lock}, 3'b110);
    hw_pulse();
    chk("lock", status.lock, 1);
    wr(`SWP_OFF_CONFIG, 32'h0);
    hw_pulse();
    chk("lock", status.lock, 0);
    wr(`SWP_OFF_CONFIG, 32'h1);
    chk("mode", status.modePersistent, 0);
    u_swp_host.xfer(1'b0, `SWP_OFF_CONFIG, 32'h0, rdQ, errQ);
    chk("configRd", rdQ, 32'h0);
    // Password low word programmed, so only the matching key unlocks
    wr(`SWP_OFF_PWD_LO, 32'h0f0f0f0f);
    wr(`SWP_OFF_KEY_LO, 32'h0);
    wr(`SWP_OFF_KEY_HI, 32'h0);
    cmd(swp_pkg::SWP_OP_PWD_UNLOCK, 32'h0, 1'b0);
    chk("badKey", {status.progErr, status.protErr, status.lock}, 3'b110);
    wr(`SWP_OFF_KEY_LO, 32'h0f0f0f0f);
    wr(`SWP_OFF_KEY_HI, 32'hffffffff);
    cmd(swp_pkg::SWP_OP_PWD_UNLOCK, 32'h0, 1'b0);
    chk("lock", status.lock, 1);
    complete_run();
  end
endmodule : swp_core_tb_top
`default_nettype wire
